// ===== logic/sspt_ctrl.sv
// Top of the synthesizer serial programming and tuning control block
`default_nettype none
`include "sspt_defs.svh"
module sspt_ctrl import sspt_pkg::*; #(
    parameter int TUNE_CYCLES = `SSPT_TUNE_CYCLES
) (
    input wire logic clk, // System clock, 100 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic shift_clk, // Host shift clock
    input wire logic load_strobe_n, // Load strobe, active low
    input wire logic serial_in_line, // Serial data from host
    input wire logic sleep_request_n, // Power-down pin, low sleeps everything
    input wire logic near_limit_if, // IF loop near compensation limit
    input wire logic near_limit_a, // High-band loop A near limit
    input wire logic near_limit_b, // High-band loop B near limit
    output logic aux_pin_out, // Auxiliary output pin
    output logic lock_margin_alarm, // Alarm, also usable without aux routing
    output logic high_band_output_sel, // 0: loop A drives high-band output, 1: loop B
    output logic high_band_pll_a_on, // Loop A powered
    output logic high_band_pll_b_on, // Loop B powered
    output logic if_pll_on, // IF loop powered
    output logic tuning_if, // IF loop tuning
    output logic tuning_a, // Loop A tuning
    output logic tuning_b, // Loop B tuning
    output logic [`SSPT_DATA_W-1:0] ndiv_a, // Loop A divider value
    output logic [`SSPT_DATA_W-1:0] ndiv_b, // Loop B divider value
    output logic [`SSPT_DATA_W-1:0] ndiv_if // IF loop divider value
);
    localparam int WORD_W = `SSPT_WORD_W;
    localparam int DATA_W = `SSPT_DATA_W;
    localparam int ADDR_W = `SSPT_ADDR_W;

    generate
        if (WORD_W != DATA_W + ADDR_W) begin : g_bad_word
            $error("sspt_ctrl: word width must be data plus address");
        end
    endgenerate

    // Address hit for a captured word
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] code);
        addr_hit = (a == code);
    endfunction

    // Register update: take the new word on its write strobe, else hold
    function automatic logic [DATA_W-1:0] load_or_hold(input logic wr, input logic [DATA_W-1:0] nv,
                                                       input logic [DATA_W-1:0] cur);
        load_or_hold = wr ? nv : cur;
    endfunction

    // Section power: the pin asleep wins; the auto bit stands in for the section bit
    function automatic logic loop_power(input logic awake, input logic auto_on, input logic sect_on);
        loop_power = awake & (auto_on | sect_on);
    endfunction

    // Clock domains:
    //  shift_clk clocks only the shift register and may stop between words;
    //  clk clocks the strobe detector, registers, sequencers and pin flops.
    //  The two are unrelated in phase; only the captured word and the synchronised reset pass between them.
    // The word is copied only after the synchronised strobe has risen; shifting
    // has stopped by then, so the word is static and needs no gray code.
    // Limitation: the strobe must stay high three clk periods before the next
    // word, or the copy could pick up bits of that word.
    // Shift clock pulses with the strobe high are harmless: the register holds.
    // Pins from outside both domains pass two clk flops before any logic.

    // Reset release: async assert, sync release
    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    wire rst_n = rst_sync_r;

    // Shift-clock domain: shift register only
    // Its reset is the clk-domain copy; the shift clock is idle when it lifts
    logic [WORD_W-1:0] shift_word;
    sspt_serial_rx #(
        .WORD_W(WORD_W)
    ) u_rx (
        .shift_clk(shift_clk),
        .rst_n(rst_n),
        .load_strobe_n(load_strobe_n),
        .serial_in_line(serial_in_line),
        .shift_word_r(shift_word)
    );

    // Pin synchronisers; first stage is read only by the second
    // Reset values match idle pins (strobe high, pin awake), so no false edge
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] pin_meta_r;
    logic [NSYNC-1:0] pin_sync_r;
    wire [NSYNC-1:0] pin_raw = {near_limit_b, near_limit_a, near_limit_if, sleep_request_n, load_strobe_n};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= 5'h03;
            pin_sync_r <= 5'h03;
        end else begin
            pin_meta_r <= pin_raw;
            pin_sync_r <= pin_meta_r;
        end
    end
    wire strobe_s = pin_sync_r[0];
    wire sleep_n_s = pin_sync_r[1];
    wire near_if_s = pin_sync_r[2];
    wire near_a_s = pin_sync_r[3];
    wire near_b_s = pin_sync_r[4];

    // Strobe rise seen in the system domain; shifting has stopped by then,
    // so the shift register is static while it is copied across
    logic strobe_d_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_d_r <= 1'b1;
        end else begin
            strobe_d_r <= strobe_s;
        end
    end
    wire load_evt = strobe_s & ~strobe_d_r;

    // Word split: data in the upper bits, address in the last bits shifted in
    wire [DATA_W-1:0] w_data = shift_word[WORD_W-1:ADDR_W];
    wire [ADDR_W-1:0] w_addr = shift_word[ADDR_W-1:0];

    // Write decode; unknown addresses match nothing and change nothing
    // A strobe with no bits framed stores the previous word again
    wire wr_main = load_evt & addr_hit(w_addr, `SSPT_ADDR_MAIN);
    wire wr_pwr = load_evt & addr_hit(w_addr, `SSPT_ADDR_PWR);
    wire wr_a = load_evt & addr_hit(w_addr, `SSPT_ADDR_NDIV_A);
    wire wr_b = load_evt & addr_hit(w_addr, `SSPT_ADDR_NDIV_B);
    wire wr_if = load_evt & addr_hit(w_addr, `SSPT_ADDR_NDIV_IF);

    // Internal registers
    logic [DATA_W-1:0] main_r, main_nxt;
    logic [DATA_W-1:0] pwr_r, pwr_nxt;
    logic [DATA_W-1:0] ndiv_a_r, ndiv_a_nxt;
    logic [DATA_W-1:0] ndiv_b_r, ndiv_b_nxt;
    logic [DATA_W-1:0] ndiv_if_r, ndiv_if_nxt;
    sspt_hb_sel_t hb_sel_r, hb_sel_nxt;

    assign main_nxt = load_or_hold(wr_main, w_data, main_r);
    assign pwr_nxt = load_or_hold(wr_pwr, w_data, pwr_r);
    assign ndiv_a_nxt = load_or_hold(wr_a, w_data, ndiv_a_r);
    assign ndiv_b_nxt = load_or_hold(wr_b, w_data, ndiv_b_r);
    assign ndiv_if_nxt = load_or_hold(wr_if, w_data, ndiv_if_r);
    // Last high-band divider written owns the shared output
    assign hb_sel_nxt = wr_a ? SSPT_HB_A : (wr_b ? SSPT_HB_B : hb_sel_r);

    // Configuration registers; all zero keeps every section off after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_r <= `SSPT_MAIN_RST;
            pwr_r <= `SSPT_PWR_RST;
        end else begin
            main_r <= main_nxt;
            pwr_r <= pwr_nxt;
        end
    end

    // Divider registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ndiv_a_r <= `SSPT_NDIV_RST;
            ndiv_b_r <= `SSPT_NDIV_RST;
            ndiv_if_r <= `SSPT_NDIV_RST;
        end else begin
            ndiv_a_r <= ndiv_a_nxt;
            ndiv_b_r <= ndiv_b_nxt;
            ndiv_if_r <= ndiv_if_nxt;
        end
    end

    // High-band owner; loop A holds the output until a divider write moves it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hb_sel_r <= SSPT_HB_A;
        end else begin
            hb_sel_r <= hb_sel_nxt;
        end
    end

    // Power decode, pin awake:
    //  auto bit set: both sections on
    //  auto bit clear: each section follows its own bit
    // Pin asleep: everything off; registers keep their contents for the wake-up
    wire auto_pd = main_r[`SSPT_AUTOPD_BIT];
    wire if_pwr = loop_power(sleep_n_s, auto_pd, pwr_r[`SSPT_PD_IF_BIT]);
    wire rf_pwr = loop_power(sleep_n_s, auto_pd, pwr_r[`SSPT_PD_RF_BIT]);
    // Only the selected high-band loop runs; the other stays off
    wire a_pwr = rf_pwr & (hb_sel_r == SSPT_HB_A);
    wire b_pwr = rf_pwr & (hb_sel_r == SSPT_HB_B);

    // Tuning sequencers; selecting the other loop powers it up and so retunes it
    logic tune_if_w, tune_a_w, tune_b_w;
    logic lock_if_w, lock_a_w, lock_b_w;

    // IF loop: retunes on power-up and on its own divider write
    sspt_tune_seq #(
        .TUNE_CYCLES(TUNE_CYCLES)
    ) u_tune_if (
        .clk(clk),
        .rst_n(rst_n),
        .powered(if_pwr),
        .freq_write(wr_if),
        .tuning_r(tune_if_w),
        .locked_r(lock_if_w)
    );

    // High-band loop A: powered only while it owns the shared output
    sspt_tune_seq #(
        .TUNE_CYCLES(TUNE_CYCLES)
    ) u_tune_a (
        .clk(clk),
        .rst_n(rst_n),
        .powered(a_pwr),
        .freq_write(wr_a),
        .tuning_r(tune_a_w),
        .locked_r(lock_a_w)
    );

    // High-band loop B: same as A, for the other band
    sspt_tune_seq #(
        .TUNE_CYCLES(TUNE_CYCLES)
    ) u_tune_b (
        .clk(clk),
        .rst_n(rst_n),
        .powered(b_pwr),
        .freq_write(wr_b),
        .tuning_r(tune_b_w),
        .locked_r(lock_b_w)
    );

    // Margin alarm: a loop counts only once locked, so a sleeping loop raises nothing
    // Limitation: the margin pins pass the synchroniser, so the alarm trails
    // them by three clk periods; the tuning term trails the sequencer by one
    wire margin_if = lock_if_w & near_if_s;
    wire margin_rf = (lock_a_w & near_a_s) | (lock_b_w & near_b_s);
    wire tuning_any = tune_if_w | tune_a_w | tune_b_w;
    // Low otherwise; host is expected to retune on a margin alarm
    wire alarm_nxt = tuning_any | margin_if | margin_rf;
    wire [1:0] aux_sel = main_r[`SSPT_AUX_ROUTE_SELECT_HI:`SSPT_AUX_ROUTE_SELECT_LO];
    wire aux_nxt = (aux_sel == SSPT_AUX_ALARM) ? alarm_nxt : 1'b0;

    // Alarm and aux flops share one next value, so the pin never shows a stale alarm
    logic alarm_r;
    logic aux_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_r <= 1'b0;
            aux_r <= 1'b0;
        end else begin
            alarm_r <= alarm_nxt;
            aux_r <= aux_nxt;
        end
    end

    // Power flops; they rise on the same edge as the sequencer's tuning flag
    logic a_on_r;
    logic b_on_r;
    logic if_on_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_on_r <= 1'b0;
            b_on_r <= 1'b0;
            if_on_r <= 1'b0;
        end else begin
            a_on_r <= a_pwr;
            b_on_r <= b_pwr;
            if_on_r <= if_pwr;
        end
    end

    // Output ownership flop
    logic hb_out_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hb_out_r <= 1'b0;
        end else begin
            hb_out_r <= (hb_sel_r == SSPT_HB_B);
        end
    end

    // Pins: every output is a flop here or in a sequencer
    assign aux_pin_out = aux_r;
    assign lock_margin_alarm = alarm_r;
    assign high_band_output_sel = hb_out_r;
    assign high_band_pll_a_on = a_on_r;
    assign high_band_pll_b_on = b_on_r;
    assign if_pll_on = if_on_r;
    assign tuning_if = tune_if_w;
    assign tuning_a = tune_a_w;
    assign tuning_b = tune_b_w;
    assign ndiv_a = ndiv_a_r;
    assign ndiv_b = ndiv_b_r;
    assign ndiv_if = ndiv_if_r;
endmodule
`default_nettype wire

// ===== logic/sspt_defs.svh
// Constants for the synthesizer serial programming and tuning control block
// Summary of operation
// - Word is 22 bits: 18 data, 4 address
// - Strobe low: sample data each shift clock rise
// - Strobe rise: copy data to addressed register
// - Strobe high: shift register holds its contents
// - Extra leading bits dropped; last 22 kept
// - Power-up or new frequency starts self-tuning
// - Tuning brings oscillator within 1% of target
// - After tuning, loop locks and holds lock
// - Only one high-band loop active at once
// - Alarm low after tuning while margin fine
// - Alarm high when a loop nears limit
// - Alarm high while any loop is tuning
// - Divider write selects that high-band loop
// - Aux pin shows alarm when select is 11
// - Tuning lasts 6.5 phase detector periods
// - Alarm is OR of both loop conditions
`ifndef SSPT_DEFS_SVH
`define SSPT_DEFS_SVH

`define SSPT_WORD_W 22
`define SSPT_DATA_W 18
`define SSPT_ADDR_W 4

// Register addresses
`define SSPT_ADDR_MAIN 4'h0
`define SSPT_ADDR_PWR 4'h2
`define SSPT_ADDR_NDIV_A 4'h3
`define SSPT_ADDR_NDIV_B 4'h4
`define SSPT_ADDR_NDIV_IF 4'h5

// Field positions
`define SSPT_AUX_ROUTE_SELECT_HI 13
`define SSPT_AUX_ROUTE_SELECT_LO 12
`define SSPT_AUTOPD_BIT 3
`define SSPT_PD_IF_BIT 1
`define SSPT_PD_RF_BIT 0

// Reset values
`define SSPT_MAIN_RST 18'h00000
`define SSPT_PWR_RST 18'h00000
`define SSPT_NDIV_RST 18'h00000

// Timing
`define SSPT_CLK_PERIOD_NS 10
`define SSPT_PD_PERIOD_NS 5000
`define SSPT_TUNE_HALF_PERIODS 13
`define SSPT_TUNE_TIME_NS (`SSPT_PD_PERIOD_NS * `SSPT_TUNE_HALF_PERIODS / 2)
`define SSPT_TUNE_CYCLES ((`SSPT_TUNE_TIME_NS + `SSPT_CLK_PERIOD_NS - 1) / `SSPT_CLK_PERIOD_NS)
`define SSPT_TUNE_CNT_W 12

`endif

// ===== logic/sspt_pkg.sv
// Types shared by the synthesizer control block
`default_nettype none
package sspt_pkg;
    typedef enum logic [1:0] {
        SSPT_LOOP_OFF,
        SSPT_LOOP_TUNE,
        SSPT_LOOP_LOCK
    } sspt_loop_state_t;

    typedef enum logic {
        SSPT_HB_A,
        SSPT_HB_B
    } sspt_hb_sel_t;

    typedef enum logic [1:0] {
        SSPT_AUX_LOW0,
        SSPT_AUX_LOW1,
        SSPT_AUX_LOW2,
        SSPT_AUX_ALARM
    } sspt_aux_sel_t;
endpackage
`default_nettype wire

// ===== logic/sspt_serial_rx.sv
// Shift register of the three-wire serial port, clocked by the host shift clock
`default_nettype none
`include "sspt_defs.svh"
module sspt_serial_rx import sspt_pkg::*; #(
    parameter int WORD_W = `SSPT_WORD_W
) (
    input wire logic shift_clk, // Host shift clock
    input wire logic rst_n, // Async reset, active low
    input wire logic load_strobe_n, // Load strobe, low enables shifting
    input wire logic serial_in_line, // Serial data
    output logic [WORD_W-1:0] shift_word_r // Last WORD_W bits shifted in
);
    logic [WORD_W-1:0] shift_word_nxt;

    generate
        if (WORD_W < 2) begin : g_bad_width
            $error("sspt_serial_rx: WORD_W too small");
        end
    endgenerate

    // Only shift while enabled; old bits fall off the top
    assign shift_word_nxt = load_strobe_n ? shift_word_r
                          : {shift_word_r[WORD_W-2:0], serial_in_line};

    // Shift clock stops between words, so nothing here may need a trailing edge
    always_ff @(posedge shift_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_word_r <= '0;
        end else begin
            shift_word_r <= shift_word_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== logic/sspt_tune_seq.sv
// Self-tuning sequencer for one loop: off, tuning window, then locked
`default_nettype none
`include "sspt_defs.svh"
module sspt_tune_seq import sspt_pkg::*; #(
    parameter int TUNE_CYCLES = `SSPT_TUNE_CYCLES
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic powered, // Loop powered level
    input wire logic freq_write, // Pulse: new frequency programmed
    output logic tuning_r, // High during tuning window
    output logic locked_r // High once the loop controls the oscillator
);
    sspt_loop_state_t state_r, state_nxt;
    logic powered_d_r;
    logic [`SSPT_TUNE_CNT_W-1:0] cnt_r, cnt_nxt;
    wire power_up = powered & ~powered_d_r;
    wire start = power_up | (powered & freq_write);
    wire done = (cnt_r == `SSPT_TUNE_CNT_W'(TUNE_CYCLES - 1));

    generate
        if (TUNE_CYCLES < 1 || TUNE_CYCLES >= (1 << `SSPT_TUNE_CNT_W)) begin : g_bad_cnt
            $error("sspt_tune_seq: TUNE_CYCLES out of range");
        end
    endgenerate

    // Restart on power-up or new frequency; a restart mid-tune starts the window over
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        if (!powered) begin
            state_nxt = SSPT_LOOP_OFF;
            cnt_nxt = '0;
        end else if (start) begin
            state_nxt = SSPT_LOOP_TUNE;
            cnt_nxt = '0;
        end else begin
            unique case (state_r)
                SSPT_LOOP_OFF: begin
                    state_nxt = SSPT_LOOP_OFF;
                end
                SSPT_LOOP_TUNE: begin
                    // Coarse oscillator trim happens in this window loop takes over after
                    if (done) begin
                        state_nxt = SSPT_LOOP_LOCK;
                    end else begin
                        cnt_nxt = cnt_r + `SSPT_TUNE_CNT_W'(1);
                    end
                end
                SSPT_LOOP_LOCK: begin
                    state_nxt = SSPT_LOOP_LOCK;
                end
                default: begin
                    state_nxt = SSPT_LOOP_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= SSPT_LOOP_OFF;
            cnt_r <= '0;
            powered_d_r <= 1'b0;
            tuning_r <= 1'b0;
            locked_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            powered_d_r <= powered;
            tuning_r <= (state_nxt == SSPT_LOOP_TUNE);
            locked_r <= (state_nxt == SSPT_LOOP_LOCK);
        end
    end
endmodule
`default_nettype wire

// ===== verif/sspt_ctrl_assertions.sv
// Port-level checks for the synthesizer control block
`default_nettype none
`include "sspt_defs.svh"
module sspt_ctrl_assertions #(
    parameter int TUNE_CYCLES = `SSPT_TUNE_CYCLES
) (
    input wire logic clk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic near_limit_if, // IF margin input
    input wire logic near_limit_a, // Loop A margin input
    input wire logic near_limit_b, // Loop B margin input
    input wire logic aux_pin_out, // Aux pin
    input wire logic lock_margin_alarm, // Alarm
    input wire logic high_band_output_sel, // High-band owner
    input wire logic high_band_pll_a_on, // Loop A powered
    input wire logic high_band_pll_b_on, // Loop B powered
    input wire logic if_pll_on, // IF powered
    input wire logic tuning_if, // IF tuning
    input wire logic tuning_a, // Loop A tuning
    input wire logic tuning_b, // Loop B tuning
    input wire logic [`SSPT_DATA_W-1:0] ndiv_a, // Loop A divider
    input wire logic [`SSPT_DATA_W-1:0] ndiv_b // Loop B divider
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    int tune_len_r;
    wire any_tune = tuning_if | tuning_a | tuning_b;
    // Length of the running loop A window; a spurious restart would stretch it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tune_len_r <= 0;
        end else begin
            tune_len_r <= tuning_a ? tune_len_r + 1 : 0;
        end
    end
    a_one_band_only: assert property (!(high_band_pll_a_on && high_band_pll_b_on))
        else $error("both high-band loops powered");
    a_powerup_tunes: assert property ($rose(if_pll_on) |-> ##[0:2] tuning_if)
        else $error("IF power-up without tuning");
    a_tune_alarm: assert property (any_tune && $past(any_tune) |-> lock_margin_alarm)
        else $error("alarm low while tuning");
    a_tune_window: assert property ($fell(tuning_a) && high_band_pll_a_on |-> tune_len_r == TUNE_CYCLES)
        else $error("tuning window length wrong");
    a_div_a_route: assert property ($changed(ndiv_a) |-> ##[0:2] !high_band_output_sel)
        else $error("loop A divider write did not select A");
    a_div_b_route: assert property ($changed(ndiv_b) |-> ##[0:2] high_band_output_sel)
        else $error("loop B divider write did not select B");
    a_if_margin: assert property ((near_limit_if && if_pll_on && !tuning_if) [*6] |-> lock_margin_alarm)
        else $error("IF near limit without alarm");
    a_b_margin: assert property ((near_limit_b && high_band_pll_b_on && !tuning_b) [*6] |-> lock_margin_alarm)
        else $error("loop B near limit without alarm");
    a_alarm_quiet: assert property ((!near_limit_if && !near_limit_a && !near_limit_b && !any_tune) [*6]
        |-> !lock_margin_alarm) else $error("alarm high with margin fine");
    a_aux_is_alarm: assert property (aux_pin_out |-> lock_margin_alarm || $past(lock_margin_alarm))
        else $error("aux pin high without alarm");
endmodule
bind sspt_ctrl sspt_ctrl_assertions #(.TUNE_CYCLES(TUNE_CYCLES)) i_chk (.clk, .reset_n, .near_limit_if,
    .near_limit_a, .near_limit_b, .aux_pin_out, .lock_margin_alarm, .high_band_output_sel, .high_band_pll_a_on,
    .high_band_pll_b_on, .if_pll_on, .tuning_if, .tuning_a, .tuning_b, .ndiv_a, .ndiv_b);
`default_nettype wire

// ===== verif/sspt_ctrl_tb.sv
// Self-checking bench of the synthesizer control block with its serial host
`default_nettype none
`include "sspt_defs.svh"
module sspt_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TC = 20;
    logic clk = 1'b0, reset_n = 1'b0, sleep_request_n = 1'b1;
    logic near_limit_if = 1'b0, near_limit_a = 1'b0, near_limit_b = 1'b0;
    wire shift_clk, load_strobe_n, serial_in_line;
    logic aux_pin_out, lock_margin_alarm, high_band_output_sel, high_band_pll_a_on, high_band_pll_b_on;
    logic if_pll_on, tuning_if, tuning_a, tuning_b;
    logic [`SSPT_DATA_W-1:0] ndiv_a, ndiv_b, ndiv_if;
    int fails = 0, checks = 0;
    // Bit 8 aux, 7 alarm, 6 select, 5 A on, 4 B on, 3 IF on, 2..0 tuning IF, A, B
    wire [17:0] flags = {9'h000, aux_pin_out, lock_margin_alarm, high_band_output_sel, high_band_pll_a_on,
        high_band_pll_b_on, if_pll_on, tuning_if, tuning_a, tuning_b};
    initial forever #5 clk = ~clk;
    sspt_ctrl #(.TUNE_CYCLES(TC)) i_dut (.clk, .reset_n, .shift_clk, .load_strobe_n, .serial_in_line,
        .sleep_request_n, .near_limit_if, .near_limit_a, .near_limit_b, .aux_pin_out, .lock_margin_alarm,
        .high_band_output_sel, .high_band_pll_a_on, .high_band_pll_b_on, .if_pll_on, .tuning_if, .tuning_a,
        .tuning_b, .ndiv_a, .ndiv_b, .ndiv_if);
    sspt_host_model i_host (.shift_clk, .load_strobe_n, .serial_in_line);
    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %0s: expected %h, seen %h", nm, e, g);
        end
    endtask
    function automatic logic [21:0] mk(input logic [17:0] d, input logic [3:0] a);
        return {d, a};
    endfunction
    // Frame with extra random leading bits, then let the sync and the update land
    task automatic wr(input logic [17:0] d, input logic [3:0] a, input int extra);
        logic [31:0] w;
        w = $urandom;
        w[21:0] = mk(d, a);
        i_host.send(w, 22 + extra);
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic idle();
        repeat (TC + 10) @(posedge clk);
        #1;
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Cuts a hang short well past the few tens of microseconds the tests need
    initial begin
        #300000;
        fails++;
        end_sim();
    end
    initial begin
        logic [17:0] d, pa, pb, pi;
        logic [3:0] ua;
        void'($urandom(32'h9C4D));
        repeat (16) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("flags", 18'h0, flags);
        chk("ndiv_if", 18'h0, ndiv_if);
        $display("test reset done");
        wr(18'h3, `SSPT_ADDR_PWR, 0);
        chk("flags", 18'h0AE, flags);
        idle();
        chk("flags", 18'h028, flags);
        $display("test power done");
        for (int i = 0; i < 4; i++) begin
            d = 18'($urandom);
            wr(d, `SSPT_ADDR_NDIV_A, i + 1);
            chk("ndiv_a", d, ndiv_a);
            chk("flags", 18'h0AA, flags);
            idle();
        end
        pa = d;
        pb = 18'($urandom);
        wr(pb, `SSPT_ADDR_NDIV_B, 0);
        chk("ndiv_b", pb, ndiv_b);
        chk("flags", 18'h0D9, flags);
        idle();
        $display("test dividers done");
        d = 18'($urandom);
        wr(d, `SSPT_ADDR_NDIV_IF, 0);
        chk("ndiv_if", d, ndiv_if);
        idle();
        i_host.send(32'h5, 4);
        repeat (8) @(posedge clk);
        #1;
        pi = {d[13:0], 4'h5};
        chk("ndiv_if", pi, ndiv_if);
        idle();
        $display("test short frame done");
        for (int i = 0; i < 3; i++) begin
            ua = (i == 0) ? 4'h1 : 4'h6 + 4'($urandom % 10);
            wr(18'($urandom), ua, 0);
            chk("ndiv_a", pa, ndiv_a);
            chk("ndiv_b", pb, ndiv_b);
            chk("ndiv_if", pi, ndiv_if);
            chk("flags", 18'h058, flags);
        end
        $display("test unmapped done");
        for (int k = 0; k < 8; k++) begin
            {near_limit_if, near_limit_a, near_limit_b} = 3'(k);
            repeat (6) @(posedge clk);
            #1;
            chk("alarm", 18'(k[2] | k[0]), 18'(lock_margin_alarm));
        end
        {near_limit_if, near_limit_a, near_limit_b} = 3'h4;
        for (int c = 0; c < 4; c++) begin
            wr(18'(c) << 12, `SSPT_ADDR_MAIN, 0);
            chk("aux", 18'(c == 3), 18'(aux_pin_out));
        end
        near_limit_if = 1'b0;
        wr(18'h00155, `SSPT_ADDR_NDIV_IF, 0);
        chk("tuning_if", 18'h1, 18'(tuning_if));
        idle();
        chk("alarm", 18'h0, 18'({aux_pin_out, lock_margin_alarm}));
        $display("test alarm done");
        sleep_request_n = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk("on", 18'h0, 18'({high_band_pll_a_on, high_band_pll_b_on, if_pll_on}));
        sleep_request_n = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk("tuning", 18'h3, 18'({tuning_if, tuning_b}));
        chk("alarm", 18'h3, 18'({aux_pin_out, lock_margin_alarm}));
        idle();
        $display("test sleep done");
        wr(18'h0, `SSPT_ADDR_PWR, 0);
        chk("on", 18'h0, 18'({high_band_pll_b_on, if_pll_on}));
        wr(18'h1 << `SSPT_AUTOPD_BIT, `SSPT_ADDR_MAIN, 0);
        chk("tuning", 18'h3, 18'({tuning_if, tuning_b}));
        idle();
        $display("test auto power done");
        end_sim();
    end
endmodule
`default_nettype wire

// ===== verif/sspt_host_model.sv
// Host side of the three-wire serial port on its own 32 ns shift clock
`default_nettype none
module sspt_host_model (
    output var logic shift_clk, // Shift clock, still between frames
    output var logic load_strobe_n, // Load strobe, low while framing
    output var logic serial_in_line // Serial data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic busy = 1'b0;
    initial begin
        shift_clk = 1'b0;
        load_strobe_n = 1'b1;
        serial_in_line = 1'b0;
    end
    // Idle data keeps toggling so shifting with the strobe high would pick up junk
    always #16 if (!busy) serial_in_line = ~serial_in_line;
    // One frame of n bits, MSB first; strobe stays high 40 ns after so the next frame keeps spacing
    task automatic send(input logic [31:0] w, input int n);
        busy = 1'b1;
        load_strobe_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_line = w[i];
            #16 shift_clk = 1'b1;
            #16 shift_clk = 1'b0;
        end
        #16 load_strobe_n = 1'b1;
        busy = 1'b0;
        // A stray shift clock pulse with the strobe high must leave the word alone
        #16 shift_clk = 1'b1;
        #16 shift_clk = 1'b0;
        #8;
    endtask
endmodule
`default_nettype wire
